/* File: tb/msl_ctl_model.sv */
// Controller model: Manchester frames on the supply line, reply decoder.
// Assumes cells of PER clocks and a supply line idling high.
`timescale 1ns/1ps
module msl_ctl_model #(
	parameter int PER = 40 // Cell length in clocks
)(
	input wire logic clk, // System clock
	input wire logic ang_dat, // Angle pin level
	input wire logic ang_oe, // Angle pin enable
	output logic line_q // Supply line level
);
	initial line_q = 1'b1;
	// Remainder, seed 111, x^3+x+1, MSB first
	function automatic logic [2:0] rem(input logic [31:0] b, input int n);
		logic [2:0] c;
		c = 3'h7;
		for (int i = n - 1; i >= 0; i--)
			c = {c[1], c[0] ^ b[i] ^ c[2], b[i] ^ c[2]};
		return c;
	endfunction : rem
	// Zero pad above n gives sync 00; a one is high then low
	task automatic send(input logic [31:0] b, input int n);
		logic [34:0] f;
		f = {b, rem(b, n)};
		for (int i = n + 4; i >= 0; i--)
		begin
			@(posedge clk) line_q <= f[i];
			repeat (PER / 2) @(posedge clk);
			line_q <= ~f[i];
			repeat (PER / 2 - 1) @(posedge clk);
		end
		@(posedge clk) line_q <= 1'b1;
	endtask : send
	// Resync on each mid-cell edge so drift cannot build up
	task automatic recv(output logic [26:0] r, output logic ok);
		ok = 1'b0;
		r = 27'h0;
		for (int k = 0; k < 200 && ang_oe !== 1'b1; k++)
			@(negedge clk);
		if (ang_oe !== 1'b1)
			return;
		repeat (PER / 4) @(negedge clk);
		for (int i = 26; i >= 0; i--)
		begin
			r[i] = ang_dat;
			for (int k = 0; k < PER && ang_dat === r[i]; k++)
				@(negedge clk);
			repeat (3 * PER / 4) @(negedge clk);
		end
		ok = 1'b1;
	endtask : recv
endmodule : msl_ctl_model

/* File: tb/tb_msl_cmd_port.sv */
// Bench for the Manchester command port: AHB registers and supply-line frames.
// Assumes a 25 MHz clock and the controller model on the supply line.
`timescale 1ns/1ps
module tb_msl_cmd_port;
	import msl_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic [31:0] d;
	logic hready;
	logic hresp;
	logic sup_line;
	logic ang_dat;
	logic ang_oe;
	logic ok;
	logic [26:0] rsp;
	int failures = 0;
	int num_checks = 0;
	// 25 MHz system clock
	always #20 clk = ~clk;
	// Size and straps tied: word transfers only, die id 1
	msl_cmd_port #(.TMO_CYC(160)) u_msl_cmd_port (.clk(clk), .reset(reset), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
		.sup_line_in(sup_line), .die_strap_low(1'b1), .die_strap_high(1'b0),
		.ang_dat(ang_dat), .ang_oe(ang_oe));
	msl_ctl_model u_msl_ctl_model (.clk(clk), .ang_dat(ang_dat), .ang_oe(ang_oe),
		.line_q(sup_line));
	task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e)
		begin
			failures++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask : check
	task automatic end_sim();
		if (failures == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim
	// Bounded wait for hready at a rising edge
	task automatic rdy();
		for (int k = 0; k < 50; k++)
		begin
			@(posedge clk);
			if (hready === 1'b1)
				return;
		end
		failures++;
		end_sim();
	endtask : rdy
	// Single word transfer; d carries write data in and read data out
	task automatic ahb(input logic w, input logic [11:0] a);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {20'h0, a};
		rdy();
		htrans <= 2'h0;
		hwdata <= d;
		rdy();
		d = hrdata;
	endtask : ahb
	// Read frame; e[16] says whether a reply is due
	task automatic rd(input logic [3:0] t, input logic [5:0] a, input logic [16:0] e);
		u_msl_ctl_model.send({21'h0, 1'b1, t, a}, 11);
		u_msl_ctl_model.recv(rsp, ok);
		check("resp", 32'({ok, rsp[26:25], rsp[18:3]}), 32'({e[16], 2'h0, e[15:0]}));
		if (e[16])
			check("crc", 32'(u_msl_ctl_model.rem(32'(rsp[24:0]), 25)), 32'h0);
	endtask : rd
	task automatic wr(input logic [3:0] t, input logic [5:0] a, input logic [15:0] v);
		u_msl_ctl_model.send({5'h0, 1'b0, t, a, v}, 27);
		repeat (8) @(posedge clk);
	endtask : wr
	// Quiet before entry; entry works with a target that does not select this die
	task automatic t_enter();
		rd(4'h2, MSL_SA_ANG, 17'h0);
		wr(4'h1, MSL_SA_KEY, MSL_ACCESS_CODE);
		ahb(1'b0, MSL_REG_STAT);
		check("mode", 32'(d[0]), 32'h1);
	endtask : t_enter
	// Even, odd, and unselected-die reads of the angle word
	task automatic t_read();
		d = 32'hABC;
		ahb(1'b1, MSL_REG_ANGLE);
		rd(4'h2, MSL_SA_ANG, 17'h10ABC);
		check("id", 32'(rsp[24:23]), 32'h1);
		rd(4'h0, 6'h21, 17'h100BC);
		rd(4'h4, MSL_SA_ANG, 17'h0);
	endtask : t_read
	// Odd write must leave the even byte alone
	task automatic t_write();
		wr(4'h2, MSL_SA_EWD, 16'h1234);
		wr(4'h0, 6'h05, 16'hAB56);
		rd(4'h2, MSL_SA_EWD, 17'h11256);
	endtask : t_write
	// Trial value in shadow first; bits outside the mask read back zero
	task automatic t_shadow();
		wr(4'h2, MSL_SA_EWA, 16'(MSL_SHADOW_OFS + 8'h01));
		wr(4'h2, MSL_SA_EWD, 16'hFFFF);
		wr(4'h2, MSL_SA_EWD + 6'h02, 16'h1234);
		wr(4'h2, MSL_SA_EWCS, 16'h8000);
		wr(4'h2, MSL_SA_ERA, 16'(MSL_SHADOW_OFS + 8'h01));
		wr(4'h2, MSL_SA_ERCS, 16'h8000);
		rd(4'h2, MSL_SA_ERD, {1'b1, MSL_SHD_MASK_DEF[31:16]});
		rd(4'h2, MSL_SA_ERD + 6'h02, 17'h11234);
	endtask : t_shadow
	// Input disabled: receiver held idle, so a read goes unanswered
	task automatic t_mute();
		d = 32'h1;
		ahb(1'b1, MSL_REG_CTRL);
		ahb(1'b0, MSL_REG_CTRL);
		check("ctrl", d, 32'h1);
		check("hresp", 32'(hresp), 32'h0);
		rd(4'h2, MSL_SA_ANG, 17'h0);
		d = 32'h0;
		ahb(1'b1, MSL_REG_CTRL);
	endtask : t_mute
	// Exit to another die still counts; reads then go unanswered
	task automatic t_exit();
		wr(4'h8, MSL_SA_KEY, 16'h0000);
		ahb(1'b0, MSL_REG_STAT);
		check("mode", 32'(d[0]), 32'h0);
		rd(4'h2, MSL_SA_ANG, 17'h0);
	endtask : t_exit
	// Reset, settle synchronisers and shadow copy, then scenarios
	initial
	begin
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		repeat (64) @(posedge clk);
		t_enter();
		t_read();
		t_write();
		t_shadow();
		t_mute();
		t_exit();
		end_sim();
	end
endmodule : tb_msl_cmd_port

/* File: verilog/msl_cmd_port.sv */
// Command layer of the Manchester port on the supply line, with an AHB-Lite slave.
// Assumes the supply comparator output arrives asynchronously on sup_line_in.
//
// Notes on behaviour
// RULE1: Controller sends commands only by modulating the supply line.
// RULE2: Code 0x62D2 enters serial mode; replies go out on the angle pin.
// RULE3: Entry code is broadcast; the target field is ignored.
// RULE4: Any other code while in serial mode returns to normal operation.
// RULE5: Exit frame is sync, target, register, code, CRC; always broadcast.
// RULE6: No read is answered outside serial mode.
// RULE7: A read latches the register address for its response.
// RULE8: Read frame: two zero sync bits, read bit one, target, address, CRC.
// RULE9: A response is sent only after a read, from the latest read address.
// RULE10: Response: sync, id, broadcast, abort, overrun, checksum flags, data, CRC.
// RULE11: Even address read gives even byte high, next odd byte low.
// RULE12: Odd address read gives that byte low and zero high.
// RULE13: Even address write stores both bytes, upper byte at the even one.
// RULE14: Odd address write stores the low byte only.
// RULE15: After power-up non-volatile words are copied into shadow words.
// RULE16: Shadow words stay writable by extended writes until reloaded.
// RULE17: Shadow words mirror non-volatile layout at an offset of 0x40.
// RULE18: Unused non-volatile bits do not exist in shadow and read zero.
// RULE19: Shadow words keep no check bits.
// RULE20: Non-volatile and shadow reads need no unlock.
// RULE21: Extended space is reached through direct registers; words up to 32 bits.
// RULE22: Controller should try values in shadow before committing them.
// RULE23: Bits are Manchester coded; one falls mid-cell, zero rises.
// RULE24: Frames end in a 3-bit x^3+x+1 CRC seeded 111, sync excluded.
// RULE25: Accept when the target bit of the strapped id is set, or all zero.
// RULE26: Status flags report broadcast, abort, overrun and checksum of earlier frames.
// RULE27: Bit period is measured on the sync bits and used for later cells.
//
// The AHB-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module msl_cmd_port #(
	parameter int TMO_CYC = msl_pkg::MSL_TMO_CYC_DEF, // Edge wait bound
	parameter logic [31:0] SHD_MASK = msl_pkg::MSL_SHD_MASK_DEF // Implemented bits
)(
	input wire logic clk, // 25 MHz system clock
	input wire logic reset, // Synchronous, active high
	input wire logic hsel, // AHB slave select
	input wire logic [31:0] haddr, // AHB address
	input wire logic [1:0] htrans, // AHB transfer type
	input wire logic hwrite, // AHB write
	input wire logic [2:0] hsize, // AHB size, word only
	input wire logic [31:0] hwdata, // AHB write data
	input wire logic hready, // AHB bus ready
	output logic [31:0] hrdata, // AHB read data
	output logic hreadyout, // AHB slave ready
	output logic hresp, // AHB response, always OKAY
	input wire logic sup_line_in, // Supply line level
	input wire logic die_strap_low, // Die id strap bit 0
	input wire logic die_strap_high, // Die id strap bit 1
	output logic ang_dat, // Angle pin level
	output logic ang_oe // Angle pin output enable
);
	import msl_pkg::*;

	localparam int PW = MSL_PER_W;

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic [2:0] pin_s1_q;
	logic [2:0] pin_s2_q;
	logic line_prev_q;
	logic [1:0] die_id;
	logic line;
	logic edge_w;

	// Straps and line come from outside the clock domain
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			pin_s1_q <= 3'h1;
			pin_s2_q <= 3'h1;
			line_prev_q <= 1'b1;
		end
		else
		begin
			pin_s1_q <= {die_strap_high, die_strap_low, sup_line_in}; // [RULE1]
			pin_s2_q <= pin_s1_q;
			line_prev_q <= pin_s2_q[0];
		end
	end
	assign line = pin_s2_q[0];
	assign die_id = pin_s2_q[2:1];
	assign edge_w = line ^ line_prev_q;

	// ****************************************************************
	// Frame receiver
	// ****************************************************************
	msl_rx_state_t rx_st_q;
	logic [PW-1:0] cnt_q;
	logic [PW-1:0] per_q;
	logic [29:0] sh_q;
	logic [2:0] crc_q;
	logic [4:0] nbit_q;
	logic s1_q;
	logic mid_q;
	logic last_q;
	logic ae_q;
	logic is_rd_q;
	logic man_dis_q;
	logic [PW-1:0] qtr;
	logic [PW-1:0] half;
	logic [PW-1:0] tqtr;
	logic [4:0] len_w;

	assign qtr = per_q >> 2;
	assign half = per_q >> 1;
	assign tqtr = half + qtr;
	assign len_w = ((nbit_q == 5'h00) ? s1_q : is_rd_q) ? MSL_RD_BITS : MSL_WR_BITS;

	// Cells are timed from the measured sync period, resynced on each mid edge
	always_ff @(posedge clk)
	begin
		if (reset || man_dis_q)
		begin
			rx_st_q <= RX_IDLE;
			cnt_q <= '0;
			per_q <= '0;
			sh_q <= '0;
			crc_q <= MSL_CRC_SEED;
			nbit_q <= '0;
			s1_q <= 1'b0;
			mid_q <= 1'b0;
			last_q <= 1'b0;
			ae_q <= 1'b0;
			is_rd_q <= 1'b0;
		end
		else
		begin
			case (rx_st_q)
				RX_IDLE:
				begin
					cnt_q <= '0;
					crc_q <= MSL_CRC_SEED; // Sync bits stay out of the CRC [RULE24]
					nbit_q <= '0;
					last_q <= 1'b0;
					ae_q <= 1'b0;
					if (edge_w && !line)
						rx_st_q <= RX_SYNC0;
				end
				RX_SYNC0:
				begin
					if (edge_w && !line)
					begin
						per_q <= cnt_q + 1'b1; // One whole sync cell [RULE27]
						cnt_q <= '0;
						rx_st_q <= RX_SYNC1;
					end
					else if (cnt_q == PW'(TMO_CYC))
						rx_st_q <= RX_IDLE;
					else
						cnt_q <= cnt_q + 1'b1;
				end
				RX_SYNC1:
				begin
					if (edge_w && line && cnt_q > qtr)
					begin
						cnt_q <= half;
						mid_q <= 1'b1;
						rx_st_q <= RX_CELL;
					end
					else if (cnt_q == tqtr)
					begin
						ae_q <= 1'b1; // [RULE26]
						rx_st_q <= RX_DONE;
					end
					else
						cnt_q <= cnt_q + 1'b1;
				end
				RX_CELL:
				begin
					if (cnt_q + 1'b1 >= per_q)
					begin
						cnt_q <= '0;
						mid_q <= 1'b0;
						if (last_q)
							rx_st_q <= RX_DONE; // Hold the end to the cell boundary
					end
					else
					begin
						cnt_q <= cnt_q + 1'b1;
						if (cnt_q == qtr)
							s1_q <= line;
						if (edge_w && !mid_q && cnt_q > qtr)
						begin
							// First-half level gives the bit [RULE23]
							sh_q <= {sh_q[28:0], s1_q};
							crc_q <= msl_crc_step(crc_q, s1_q); // [RULE24]
							nbit_q <= nbit_q + 1'b1;
							mid_q <= 1'b1;
							cnt_q <= half;
							last_q <= (nbit_q + 1'b1 == len_w);
							if (nbit_q == 5'h00)
								is_rd_q <= s1_q; // [RULE8]
						end
						else if (!mid_q && cnt_q == tqtr)
						begin
							ae_q <= 1'b1; // Missing mid-cell edge [RULE26]
							rx_st_q <= RX_DONE;
						end
					end
				end
				RX_DONE:
					rx_st_q <= RX_IDLE;
				default:
					rx_st_q <= RX_IDLE;
			endcase
		end
	end

	// ****************************************************************
	// Frame decode
	// ****************************************************************
	logic frame_done;
	logic crc_bad;
	logic f_ok;
	logic [3:0] f_tid;
	logic [5:0] f_addr;
	logic [15:0] f_data;
	logic sel_w;
	logic key_w;
	logic rd_go_w;
	logic wr_go_w;
	logic serial_mode_q;
	logic tx_busy;

	assign frame_done = (rx_st_q == RX_DONE);
	assign crc_bad = (crc_q != 3'h0); // Remainder over data and token [RULE24]
	assign f_ok = frame_done && !ae_q && !crc_bad;
	assign f_tid = is_rd_q ? sh_q[12:9] : sh_q[28:25]; // [RULE8]
	assign f_addr = is_rd_q ? sh_q[8:3] : sh_q[24:19];
	assign f_data = sh_q[18:3];
	assign sel_w = (f_tid == 4'h0) || f_tid[die_id]; // [RULE25]
	assign key_w = f_ok && !is_rd_q && (f_addr == MSL_SA_KEY); // No id check [RULE3] [RULE5]
	assign rd_go_w = f_ok && is_rd_q && sel_w && serial_mode_q; // [RULE6]
	assign wr_go_w = f_ok && !is_rd_q && !(f_addr == MSL_SA_KEY) && sel_w && serial_mode_q;

	// Serial mode entry and exit
	always_ff @(posedge clk)
	begin
		if (reset)
			serial_mode_q <= 1'b0;
		else if (key_w && f_data == MSL_ACCESS_CODE)
			serial_mode_q <= 1'b1; // [RULE2] [RULE3]
		else if (key_w)
			serial_mode_q <= 1'b0; // [RULE4]
	end

	// ****************************************************************
	// Status flags and response launch
	// ****************************************************************
	msl_flags_t pend_q;
	msl_flags_t stat_q;
	msl_flags_t nf_w;
	logic [5:0] rd_addr_q;
	logic tx_start_q;

	assign nf_w = '{bc: (f_tid == 4'h0) && !ae_q, ae: ae_q, ovr: tx_busy, cs: crc_bad && !ae_q};

	// A read hands out earlier flags and restarts collection with its own [RULE26]
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			pend_q <= '0;
			stat_q <= '0;
			rd_addr_q <= '0;
			tx_start_q <= 1'b0;
		end
		else
		begin
			tx_start_q <= rd_go_w; // [RULE9]
			if (frame_done)
				pend_q <= rd_go_w ? nf_w : (pend_q | nf_w);
			if (rd_go_w)
			begin
				stat_q <= pend_q;
				rd_addr_q <= f_addr; // [RULE7]
			end
		end
	end

	// ****************************************************************
	// Direct serial registers
	// ****************************************************************
	logic [7:0] ewa_q;
	logic [7:0] era_q;
	logic [31:0] ewd_q;
	logic [31:0] erd_q;
	logic rdn_q;
	logic wdn_q;
	logic [11:0] angle_q;
	logic [8:0] wb_ewcs;
	logic [8:0] wb_ercs;
	logic [8:0] wb_ewa;
	logic [8:0] wb_era;
	logic ext_wr_w;
	logic ext_rd_w;

	// Byte lanes hit by a write: even takes both, odd the low byte only
	function automatic logic [8:0] wsel(input logic [5:0] t);
		logic [8:0] r;
		r = '0;
		if (wr_go_w && !f_addr[0] && t == f_addr)
			r = {1'b1, f_data[15:8]}; // [RULE13]
		else if (wr_go_w && t == (f_addr | 6'h01))
			r = {1'b1, f_data[7:0]}; // [RULE14]
		return r;
	endfunction : wsel

	// Byte view of the direct registers
	function automatic logic [7:0] rbyte(input logic [5:0] a);
		logic [7:0] r;
		r = 8'h00;
		case (a)
			MSL_SA_EWA: r = ewa_q;
			MSL_SA_EWCS1: r = {7'h00, wdn_q};
			MSL_SA_ERA: r = era_q;
			MSL_SA_ERCS1: r = {7'h00, rdn_q};
			MSL_SA_ANG: r = {4'h0, angle_q[11:8]};
			MSL_SA_ANG + 6'h01: r = angle_q[7:0];
			default:
			begin
				if (a >= MSL_SA_EWD && a < MSL_SA_EWCS)
					r = ewd_q[8'(31 - 8 * int'(a - MSL_SA_EWD)) -: 8];
				else if (a >= MSL_SA_ERD && a < MSL_SA_ERD + 6'h04)
					r = erd_q[8'(31 - 8 * int'(a - MSL_SA_ERD)) -: 8];
			end
		endcase
		return r;
	endfunction : rbyte

	// A process, not assigns: the function reads the decoded frame directly
	always_comb
	begin
		wb_ewcs = wsel(MSL_SA_EWCS);
		wb_ercs = wsel(MSL_SA_ERCS);
		wb_ewa = wsel(MSL_SA_EWA);
		wb_era = wsel(MSL_SA_ERA);
	end
	assign ext_wr_w = wb_ewcs[8] && wb_ewcs[MSL_GO_BIT]; // [RULE21]
	assign ext_rd_w = wb_ercs[8] && wb_ercs[MSL_GO_BIT]; // [RULE21]

	// Write data register, one byte lane per entry
	for (genvar i = 0; i < 4; i++)
	begin : g_ewd
		logic [8:0] wb;
		// Lane strobe, re-evaluated on every frame change
		always_comb
			wb = wsel(MSL_SA_EWD + 6'(i));
		always_ff @(posedge clk)
		begin
			if (reset)
				ewd_q[31-8*i -: 8] <= 8'h00;
			else if (wb[8])
				ewd_q[31-8*i -: 8] <= wb[7:0]; // [RULE13] [RULE14]
		end
	end

	// Address registers and write done bit; a new write address clears it
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			ewa_q <= 8'h00;
			era_q <= 8'h00;
			wdn_q <= 1'b0;
		end
		else
		begin
			if (wb_ewa[8])
				ewa_q <= wb_ewa[7:0];
			if (wb_era[8])
				era_q <= wb_era[7:0];
			if (ext_wr_w)
				wdn_q <= 1'b1;
			else if (wb_ewa[8])
				wdn_q <= 1'b0;
		end
	end

	// ****************************************************************
	// Extended space: non-volatile words and shadow copies
	// ****************************************************************
	logic [31:0] nv_mem [MSL_NV_WORDS];
	logic [31:0] shadow_q [MSL_NV_WORDS];
	logic [5:0] ld_idx_q;
	logic ld_busy_q;
	logic [31:0] ext_word;

	// Non-volatile words keep no reset; only data bits are modelled
	always_ff @(posedge clk)
	begin
		if (ext_wr_w && ewa_q < MSL_SHADOW_OFS)
			nv_mem[ewa_q[5:0]] <= ewd_q & SHD_MASK;
	end

	// Power-up copy, then extended writes override until the next reload
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			ld_idx_q <= '0;
			ld_busy_q <= 1'b1;
		end
		else if (ld_busy_q)
		begin
			shadow_q[ld_idx_q] <= nv_mem[ld_idx_q] & SHD_MASK; // [RULE15] [RULE19]
			ld_idx_q <= ld_idx_q + 1'b1;
			if (ld_idx_q == 6'(MSL_NV_WORDS - 1))
				ld_busy_q <= 1'b0;
		end
		else if (ext_wr_w && ewa_q >= MSL_SHADOW_OFS && ewa_q < 2 * MSL_SHADOW_OFS)
			shadow_q[6'(ewa_q - MSL_SHADOW_OFS)] <= ewd_q & SHD_MASK; // [RULE16] [RULE17]
	end

	// Reads need no unlock; unused bits were never stored [RULE18] [RULE20]
	always_comb
	begin
		ext_word = 32'h0000_0000;
		if (era_q < MSL_SHADOW_OFS)
			ext_word = nv_mem[era_q[5:0]];
		else if (era_q < 2 * MSL_SHADOW_OFS)
			ext_word = shadow_q[6'(era_q - MSL_SHADOW_OFS)]; // [RULE17]
	end

	// Read data and done bit
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			erd_q <= 32'h0000_0000;
			rdn_q <= 1'b0;
		end
		else if (ext_rd_w)
		begin
			erd_q <= ext_word; // [RULE21]
			rdn_q <= 1'b1;
		end
		else if (wb_era[8])
			rdn_q <= 1'b0;
	end

	// ****************************************************************
	// Response frame and transmitter
	// ****************************************************************
	msl_resp_t resp_w;
	logic [2:0] rcrc_w;
	logic [MSL_RESP_BITS-1:0] tx_frame;

	always_comb
	begin
		resp_w.id = stat_q.bc ? 2'b00 : die_id; // [RULE10]
		resp_w.flags = stat_q;
		if (rd_addr_q[0])
			resp_w.data = {8'h00, rbyte(rd_addr_q)}; // [RULE12]
		else
			resp_w.data = {rbyte(rd_addr_q), rbyte(rd_addr_q | 6'h01)}; // [RULE11]
		rcrc_w = MSL_CRC_SEED;
		for (int i = MSL_RESP_CRC_BITS - 1; i >= 0; i--)
			rcrc_w = msl_crc_step(rcrc_w, resp_w[i]); // [RULE24]
	end
	assign tx_frame = {2'b00, resp_w, rcrc_w}; // [RULE10]

	msl_man_tx #(.NBITS(MSL_RESP_BITS), .PW(PW)) u_tx (
		.clk(clk),
		.reset(reset),
		.start(tx_start_q),
		.frame(tx_frame),
		.half_cyc(half),
		.line_q(ang_dat),
		.drive_q(ang_oe),
		.busy_q(tx_busy)
	);

	// ****************************************************************
	// AHB-Lite slave, zero wait states
	// ****************************************************************
	logic ahb_req;
	logic wr_pend_q;
	logic [11:0] wr_addr_q;

	assign ahb_req = hsel && htrans[1] && hready;

	// Read data is fetched in the address phase so the data phase never waits
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_pend_q <= 1'b0;
			wr_addr_q <= 12'h000;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_pend_q <= ahb_req && hwrite;
			wr_addr_q <= haddr[11:0];
			if (ahb_req && !hwrite)
			begin
				case (haddr[11:0])
					MSL_REG_CTRL: hrdata <= {31'h0, man_dis_q};
					MSL_REG_STAT: hrdata <= {14'h0, die_id, 2'h0, rd_addr_q, 1'b0, pend_q,
						tx_busy, ld_busy_q, serial_mode_q};
					MSL_REG_ANGLE: hrdata <= {20'h0, angle_q};
					default: hrdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Software-written controls
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			man_dis_q <= 1'b0;
			angle_q <= 12'h000;
		end
		else if (wr_pend_q && wr_addr_q == MSL_REG_CTRL)
			man_dis_q <= hwdata[0];
		else if (wr_pend_q && wr_addr_q == MSL_REG_ANGLE)
			angle_q <= hwdata[11:0];
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	entry_code_a: assert property (key_w && f_data == MSL_ACCESS_CODE |=> serial_mode_q) // [RULE2]
		else $error("entry code did not enter serial mode");
	exit_code_a: assert property (key_w && f_data != MSL_ACCESS_CODE |=> !serial_mode_q) // [RULE4]
		else $error("exit code did not leave serial mode");
	read_gate_a: assert property (tx_start_q |-> serial_mode_q && $past(rd_go_w)) // [RULE6]
		else $error("response launched without a read in serial mode");
	read_latch_a: assert property (rd_go_w && !tx_busy |=> // [RULE7]
		rd_addr_q == $past(f_addr) ##1 ang_oe)
		else $error("read address not latched or response not driven");
	odd_read_a: assert property (tx_start_q && rd_addr_q[0] |-> tx_frame[18:11] == 8'h00) // [RULE12]
		else $error("odd read high byte not zero");
	even_write_a: assert property (wr_go_w && f_addr == MSL_SA_EWD |=> // [RULE13]
		ewd_q[31:16] == $past(f_data))
		else $error("even write did not store both bytes");
	odd_write_a: assert property (wr_go_w && f_addr == MSL_SA_EWD + 6'h01 |=> // [RULE14]
		ewd_q[23:16] == $past(f_data[7:0]) && $stable(ewd_q[31:24]))
		else $error("odd write touched the wrong byte");
	shadow_zero_a: assert property (ext_rd_w && era_q >= MSL_SHADOW_OFS |=> // [RULE18]
		(erd_q & ~SHD_MASK) == 32'h0000_0000)
		else $error("unimplemented shadow bits read nonzero");
	id_select_a: assert property (f_ok && is_rd_q && f_tid != 4'h0 && !f_tid[die_id] |=> // [RULE25]
		!tx_start_q)
		else $error("command accepted for another die");
	crc_reject_a: assert property (frame_done && crc_bad |=> !tx_start_q) // [RULE24]
		else $error("frame with bad checksum acted upon");
endmodule : msl_cmd_port

/* File: verilog/msl_man_tx.sv */
// Manchester frame transmitter for the angle output pin.
// Assumes the half-cell length is steady for the whole frame.
`timescale 1ns/1ps
module msl_man_tx #(
	parameter int NBITS = 27,
	parameter int PW = 15
)(
	input wire logic clk, // System clock
	input wire logic reset, // Synchronous, active high
	input wire logic start, // One-cycle launch pulse
	input wire logic [NBITS-1:0] frame, // Bits, first sent in the MSB
	input wire logic [PW-1:0] half_cyc, // Half cell in clocks
	output logic line_q, // Line level
	output logic drive_q, // Output enable
	output logic busy_q // Frame in flight
);
	logic [NBITS-1:0] sh_q;
	logic [PW-1:0] cnt_q;
	logic [5:0] left_q;
	logic second_q;

	// ****************************************************************
	// Cell sequencer
	// ****************************************************************
	// One is high then low, zero is low then high [RULE23]
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			sh_q <= '0;
			cnt_q <= '0;
			left_q <= '0;
			second_q <= 1'b0;
			line_q <= 1'b1;
			drive_q <= 1'b0;
			busy_q <= 1'b0;
		end
		else if (start && !busy_q)
		begin
			sh_q <= frame;
			cnt_q <= '0;
			left_q <= 6'(NBITS);
			second_q <= 1'b0;
			line_q <= frame[NBITS-1];
			drive_q <= 1'b1;
			busy_q <= 1'b1;
		end
		else if (busy_q)
		begin
			if (cnt_q + 1'b1 >= half_cyc)
			begin
				cnt_q <= '0;
				if (!second_q)
				begin
					second_q <= 1'b1;
					line_q <= ~line_q; // Mid-cell edge
				end
				else if (left_q == 6'h01)
				begin
					busy_q <= 1'b0; // Release after last cell
					drive_q <= 1'b0;
					line_q <= 1'b1;
				end
				else
				begin
					second_q <= 1'b0;
					sh_q <= {sh_q[NBITS-2:0], 1'b0};
					line_q <= sh_q[NBITS-2];
					left_q <= left_q - 1'b1;
				end
			end
			else
				cnt_q <= cnt_q + 1'b1;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	frame_drive_a: assert property (@(posedge clk) disable iff (reset)
		(start && !busy_q) |=> drive_q && line_q == $past(frame[NBITS-1])) // [RULE23]
		else $error("transmitter did not start the first cell");
endmodule : msl_man_tx

/* File: verilog/msl_pkg.sv */
// Constants, field layouts and types shared by the Manchester supply-line port.
// Assumes a single 25 MHz system clock and an AHB-Lite register slave.
package msl_pkg;

	// ****************************************************************
	// Clock and link timing
	// ****************************************************************
	localparam int MSL_CLK_HZ = 25_000_000;
	localparam int MSL_MIN_BPS = 2200;
	// Slowest legal cell, doubled, bounds the wait for the second sync falling edge
	localparam int MSL_TMO_CYC_DEF = 2 * MSL_CLK_HZ / MSL_MIN_BPS;
	localparam int MSL_PER_W = 15;

	// ****************************************************************
	// Frame layout
	// ****************************************************************
	localparam logic [15:0] MSL_ACCESS_CODE = 16'h62D2;
	localparam logic [2:0] MSL_CRC_SEED = 3'h7;
	localparam logic [4:0] MSL_RD_BITS = 5'h0E;
	localparam logic [4:0] MSL_WR_BITS = 5'h1E;
	localparam int MSL_RESP_BITS = 27;
	localparam int MSL_RESP_CRC_BITS = 22;

	// ****************************************************************
	// Direct serial register byte addresses
	// ****************************************************************
	localparam logic [5:0] MSL_SA_EWA = 6'h03;
	localparam logic [5:0] MSL_SA_EWD = 6'h04;
	localparam logic [5:0] MSL_SA_EWCS = 6'h08;
	localparam logic [5:0] MSL_SA_EWCS1 = 6'h09;
	localparam logic [5:0] MSL_SA_ERA = 6'h0B;
	localparam logic [5:0] MSL_SA_ERCS = 6'h0C;
	localparam logic [5:0] MSL_SA_ERCS1 = 6'h0D;
	localparam logic [5:0] MSL_SA_ERD = 6'h0E;
	localparam logic [5:0] MSL_SA_ANG = 6'h20;
	localparam logic [5:0] MSL_SA_KEY = 6'h3E;
	localparam int MSL_GO_BIT = 7;

	// ****************************************************************
	// Extended space
	// ****************************************************************
	localparam logic [7:0] MSL_SHADOW_OFS = 8'h40;
	localparam logic [31:0] MSL_SHD_MASK_DEF = 32'h03FF_FFFF;
	localparam int MSL_NV_WORDS = 64;

	// ****************************************************************
	// AHB register byte offsets
	// ****************************************************************
	localparam logic [11:0] MSL_REG_CTRL = 12'h000;
	localparam logic [11:0] MSL_REG_STAT = 12'h004;
	localparam logic [11:0] MSL_REG_ANGLE = 12'h008;

	typedef struct packed {
		logic bc;
		logic ae;
		logic ovr;
		logic cs;
	} msl_flags_t;

	typedef struct packed {
		logic [1:0] id;
		msl_flags_t flags;
		logic [15:0] data;
	} msl_resp_t;

	typedef enum logic [2:0] {
		RX_IDLE = 3'b000,
		RX_SYNC0 = 3'b001,
		RX_SYNC1 = 3'b011,
		RX_CELL = 3'b010,
		RX_DONE = 3'b110
	} msl_rx_state_t;

	// One step of the x^3+x+1 serial remainder
	function automatic logic [2:0] msl_crc_step(input logic [2:0] c, input logic b);
		logic fb;
		fb = b ^ c[2];
		return {c[1], c[0] ^ fb, fb};
	endfunction : msl_crc_step

endpackage : msl_pkg
